// [hw/wwd_core.sv]
/*
 * Windowed watchdog: prescaled counter, window check, sleep handling,
 * clearing conditions, status flags and an Avalon-MM register slave.
 * Assumes configuration inputs are stable straps and all core strobes are
 * synchronous to clk_i.
 */
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Sleep entry clears count; resume from zero.
// - Sleep exit clears; hold zero during startup.
// - Crystal clocks hold clear; others clear once.
// - Time-out in sleep wakes, no reset.
// - Sleep time-out drives expiry and sleep flags.
// - Watchdog reset drives watchdog reset flag.
// - Disable, soft off, sleep, clear, failure clear.
// - Oscillator divider change leaves count alone.
// - Period select doubles ratio; high codes minimum.
// - Period select reset from configuration or 01011.
// - Period select read-only unless configuration ones.
// - Soft enable counts only in mode 01.
// - Clock select picks one of four sources.
// - Clock select reset from configuration or 000; read-only unless configuration ones.
// - Window code opens eighths of period.
// - Window select from configuration; read-only otherwise.
// - Window opens at count threshold per code.
// - Armed status reads at timer bit 2.
// - Prescaler count readable, eighteen bits, read-only.
// - Windowed clear needs arming read first.
// - Bad clear resets and drops violation flag.
// - Control register writes clear the count.
// - Awake time-out resets the device.
module wwd_core
	import wwd_pkg::*;
#(
	parameter int CNT_W = 23	// Counter width; must hold the longest period
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	// Avalon-MM slave, byte address
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [DATA_W-1:0] avs_writedata_i,
	input wire logic [BE_W-1:0] avs_byteenable_i,
	output logic [DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Configuration straps
	input wire logic [1:0] watchdog_mode_config_i,
	input wire logic [4:0] period_config_i,
	input wire logic [2:0] clock_config_i,
	input wire logic [2:0] window_config_i,
	// Oscillator tick strobes: low, mid, secondary, external
	input wire logic [3:0] osc_tick_i,
	// Core events
	input wire logic sleep_i,
	input wire logic watchdog_clear_instr_i,
	input wire logic osc_fail_i,
	input wire logic ost_running_i,
	input wire logic crystal_clock_i,
	input wire logic flags_restore_i,
	// Results
	output logic wdt_reset_o,
	output logic wake_o,
	output logic expiry_flag_n_o,
	output logic sleep_entered_flag_n_o,
	output logic watchdog_reset_flag_n_o,
	output logic window_violation_flag_n_o
);

	// Refuse a counter too short for the longest period
	if (CNT_W < int'(PS_MAX) + PS_BASE_SHIFT || CNT_W > 31) begin : g_bad_width
		$error("wwd_core: CNT_W must lie between 23 and 31");
	end

	// Whole state of the watchdog
	typedef struct packed {
		logic wait_hi;	// Avalon waitrequest
		logic [REG_W-1:0] rdata;	// Read data byte
		logic soft_enable;	// Soft enable
		logic [PS_W-1:0] ps;	// Period select
		logic [CS_W-1:0] cs;	// Clock select
		logic [WIN_W-1:0] win;	// Window select
		logic [CNT_W-1:0] cnt;	// Prescaler and window count
		logic armed;	// Armed by a control_a read
		logic sleep_prev;	// Sleep level one cycle back
		logic ost_hold;	// Holding clear until startup ends
		logic reset_p;	// Watchdog reset pulse
		logic wake_p;	// Wake pulse
		logic expiry_n;	// Expiry flag, active low
		logic sleep_n;	// Sleep entered flag, active low
		logic watchdog_reset_flag_n_n;	// Watchdog reset flag, active low
		logic wv_n;	// Window violation flag, active low
	} wwd_state_t;

	wwd_state_t s_q;	// Registered state
	wwd_state_t s_d;	// Next state

	wwd_tick_if tick_bus();	// Link to the tick selector

	// Shift of the period tap; out-of-range codes give the minimum
	function automatic logic [4:0] tap_shift(input logic [PS_W-1:0] ps);
		if (ps > PS_MAX) begin
			tap_shift = PS_MIN;
		end else begin
			tap_shift = ps;
		end
	endfunction

	// Window count value at which the window opens
	function automatic logic [TMR_W-1:0] open_threshold(input logic [WIN_W-1:0] win);
		logic [WIN_W-1:0] closed_eighths;
		closed_eighths = WIN_ALWAYS_OPEN - win;
		open_threshold = {closed_eighths, 2'b00};
	endfunction

	// Period terminal count for a select code
	function automatic logic [CNT_W-1:0] period_mask(input logic [PS_W-1:0] ps);
		logic [CNT_W:0] one_hot;
		one_hot = (CNT_W+1)'(1) << (int'(tap_shift(ps)) + PS_BASE_SHIFT);
		period_mask = CNT_W'(one_hot - (CNT_W+1)'(1));
	endfunction

	// Bus and event decode
	logic [7:0] idx;	// Register index from the address
	logic req;	// Read or write present
	logic done;	// Transfer completes at this edge
	logic wr_a;	// Completed write to control_a
	logic wr_b;	// Completed write to control_b
	logic active;	// Watchdog counting enabled
	logic sleep_enter;	// First cycle of sleep
	logic sleep_exit;	// First cycle awake again
	logic windowed;	// Window narrower than the period
	logic [TMR_W-1:0] tmr;	// Five window count bits
	logic in_open;	// Count inside the open window
	logic bad_clear;	// Clear instruction that violates the window
	logic good_clear;	// Clear instruction accepted
	logic clr;	// Any cause other than a time-out that zeroes the count
	logic timeout;	// Period completes on this tick

	assign idx = avs_address_i[IDX_LSB +: 8];
	assign req = avs_read_i | avs_write_i;
	assign done = req & ~s_q.wait_hi;
	assign wr_a = done & avs_write_i & avs_byteenable_i[0] & (idx == IDX_CTRL_A);
	assign wr_b = done & avs_write_i & avs_byteenable_i[0] & (idx == IDX_CTRL_B);
	assign sleep_enter = sleep_i & ~s_q.sleep_prev;
	assign sleep_exit = ~sleep_i & s_q.sleep_prev;
	assign tick_bus.sel = s_q.cs;

	// Enable by operating mode, soft enable and sleep
	always_comb begin
		case (watchdog_mode_config_i)
			MODE_ON: begin
				active = 1'b1;
			end
			MODE_NO_SLEEP: begin
				active = ~sleep_i;
			end
			MODE_SOFT: begin
				active = s_q.soft_enable;
			end
			default: begin
				active = 1'b0;	// Off; soft enable ignored
			end
		endcase
	end

	// Window position of the count and clear instruction checks
	always_comb begin
		tmr = TMR_W'(s_q.cnt >> tap_shift(s_q.ps));
		windowed = s_q.win != WIN_ALWAYS_OPEN;
		in_open = ~windowed | (tmr >= open_threshold(s_q.win));
		bad_clear = active & watchdog_clear_instr_i & windowed & (~s_q.armed | ~in_open);
		good_clear = active & watchdog_clear_instr_i & ~bad_clear;
		clr = ~active
			| sleep_enter
			| sleep_exit
			| s_q.ost_hold
			| good_clear
			| osc_fail_i
			| wr_a | wr_b;
		timeout = ~clr & tick_bus.tick & (s_q.cnt == period_mask(s_q.ps));
	end

	// Next state
	always_comb begin
		s_d = s_q;
		s_d.sleep_prev = sleep_i;
		s_d.reset_p = 1'b0;
		s_d.wake_p = 1'b0;

		// Waitrequest drops for one cycle after each request is seen
		s_d.wait_hi = ~(req & s_q.wait_hi);

		// Read data captured as the request is first seen, while waitrequest is high
		if (req & s_q.wait_hi & avs_read_i) begin
			case (idx)
				IDX_CTRL_A: begin
					s_d.rdata = BYTE_ZERO;
					s_d.rdata[SEN_BIT] = s_q.soft_enable;
					s_d.rdata[PS_LSB +: PS_W] = s_q.ps;
				end
				IDX_CTRL_B: begin
					s_d.rdata = BYTE_ZERO;
					s_d.rdata[CS_LSB +: CS_W] = s_q.cs;
					s_d.rdata[WIN_LSB +: WIN_W] = s_q.win;
				end
				IDX_PSC_LO: begin
					s_d.rdata = s_q.cnt[7:0];
				end
				IDX_PSC_HI: begin
					s_d.rdata = s_q.cnt[15:8];
				end
				IDX_TIMER: begin
					s_d.rdata = BYTE_ZERO;
					s_d.rdata[TMR_LSB +: TMR_W] = tmr;
					s_d.rdata[STATE_BIT] = s_q.armed;
					s_d.rdata[1:0] = s_q.cnt[PSC_TOP_LSB +: 2];
				end
				default: begin
					s_d.rdata = BYTE_ZERO;	// Unmapped reads as zero
				end
			endcase
		end

		// Reading control_a arms the window check
		if (done & avs_read_i & (idx == IDX_CTRL_A)) begin
			s_d.armed = 1'b1;
		end

		// Register writes; locked fields keep their value
		if (wr_a) begin
			s_d.soft_enable = avs_writedata_i[SEN_BIT];
			if (period_config_i == PS_CFG_SOFT) begin
				s_d.ps = avs_writedata_i[PS_LSB +: PS_W];
			end
		end
		if (wr_b) begin
			if (clock_config_i == CS_CFG_SOFT) begin
				s_d.cs = avs_writedata_i[CS_LSB +: CS_W];
			end
			if (window_config_i == WIN_CFG_SOFT) begin
				s_d.win = avs_writedata_i[WIN_LSB +: WIN_W];
			end
		end

		// Startup hold after waking on a crystal clock
		if (sleep_exit & crystal_clock_i) begin
			s_d.ost_hold = ost_running_i;
		end else if (~ost_running_i) begin
			s_d.ost_hold = 1'b0;
		end

		// Counter: cleared, wrapped on time-out, or stepped per tick
		// The oscillator divider has no input here, so it never clears the count
		if (clr | timeout) begin
			s_d.cnt = '0;
		end else if (tick_bus.tick) begin
			s_d.cnt = s_q.cnt + CNT_W'(1);
		end

		// An accepted clear drops the arming
		if (good_clear) begin
			s_d.armed = 1'b0;
		end

		// Firmware restores flags; hardware events below win
		if (flags_restore_i) begin
			s_d.expiry_n = 1'b1;
			s_d.sleep_n = 1'b1;
			s_d.watchdog_reset_flag_n_n = 1'b1;
			s_d.wv_n = 1'b1;
		end
		if (sleep_enter) begin
			s_d.sleep_n = 1'b0;
		end

		// Window violation resets like a time-out
		if (bad_clear) begin
			s_d.reset_p = 1'b1;
			s_d.wv_n = 1'b0;
			s_d.watchdog_reset_flag_n_n = 1'b0;
			s_d.armed = 1'b0;
		end

		// Time-out: wake in sleep, reset when awake
		if (timeout) begin
			s_d.expiry_n = 1'b0;
			if (sleep_i) begin
				s_d.wake_p = 1'b1;
				s_d.sleep_n = 1'b0;
			end else begin
				s_d.reset_p = 1'b1;
				s_d.watchdog_reset_flag_n_n = 1'b0;
				s_d.armed = 1'b0;
			end
		end
	end

	// Register the state; reset loads fields from the straps
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.wait_hi <= 1'b1;
			s_q.soft_enable <= 1'b0;
			s_q.ps <= (period_config_i == PS_CFG_SOFT) ? PS_RESET_SOFT : period_config_i;
			s_q.cs <= (clock_config_i == CS_CFG_SOFT) ? CS_RESET_SOFT : clock_config_i;
			s_q.win <= window_config_i;
			s_q.expiry_n <= 1'b1;
			s_q.sleep_n <= 1'b1;
			s_q.watchdog_reset_flag_n_n <= 1'b1;
			s_q.wv_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Tick source selector
	wwd_tick_sel u_tick_sel (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.osc_tick_i(osc_tick_i),
		.tick_if(tick_bus.src)
	);

	// Outputs straight from the state register
	assign avs_readdata_o = {{(DATA_W-REG_W){1'b0}}, s_q.rdata};
	assign avs_waitrequest_o = s_q.wait_hi;
	assign wdt_reset_o = s_q.reset_p;
	assign wake_o = s_q.wake_p;
	assign expiry_flag_n_o = s_q.expiry_n;
	assign sleep_entered_flag_n_o = s_q.sleep_n;
	assign watchdog_reset_flag_n_o = s_q.watchdog_reset_flag_n_n;
	assign window_violation_flag_n_o = s_q.wv_n;

endmodule

`default_nettype wire

// [hw/wwd_pkg.sv]
/*
 * Constants shared by the windowed watchdog: register indices, field
 * positions, configuration codes and reset values.
 * Assumes the register indices are word indices on a byte-addressed bus.
 */
package wwd_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL_A = 8'h78;
	localparam logic [7:0] IDX_CTRL_B = 8'h79;
	localparam logic [7:0] IDX_PSC_LO = 8'h7a;
	localparam logic [7:0] IDX_PSC_HI = 8'h7b;
	localparam logic [7:0] IDX_TIMER = 8'h7c;

	// Bus geometry
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	localparam int REG_W = 8;
	localparam int IDX_LSB = 2;

	// Field positions in watchdog_control_a
	localparam int SEN_BIT = 0;
	localparam int PS_LSB = 1;
	localparam int PS_W = 5;
	// Field positions in watchdog_control_b
	localparam int CS_LSB = 4;
	localparam int CS_W = 3;
	localparam int WIN_LSB = 0;
	localparam int WIN_W = 3;
	// Field positions in window_timer_status
	localparam int TMR_LSB = 3;
	localparam int TMR_W = 5;
	localparam int STATE_BIT = 2;
	localparam int PSC_TOP_LSB = 16;
	localparam int PSC_W = 18;

	// Operating mode configuration codes
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_SOFT = 2'h1;
	localparam logic [1:0] MODE_NO_SLEEP = 2'h2;
	localparam logic [1:0] MODE_ON = 2'h3;

	// Period select codes
	localparam logic [4:0] PS_CFG_SOFT = 5'h1f;
	localparam logic [4:0] PS_RESET_SOFT = 5'h0b;
	localparam logic [4:0] PS_MAX = 5'h12;
	localparam logic [4:0] PS_MIN = 5'h00;
	localparam int PS_BASE_SHIFT = 5;

	// Clock select codes
	localparam logic [2:0] CS_CFG_SOFT = 3'h7;
	localparam logic [2:0] CS_RESET_SOFT = 3'h0;
	localparam logic [2:0] CS_FIRST_RSVD = 3'h4;

	// Window select codes
	localparam logic [2:0] WIN_CFG_SOFT = 3'h7;
	localparam logic [2:0] WIN_ALWAYS_OPEN = 3'h7;

	// Zero value of read data bytes, unused bits and unmapped registers
	localparam logic [7:0] BYTE_ZERO = 8'h00;

endpackage

// [hw/wwd_tick_if.sv]
/*
 * Carries the selected clock source code from the watchdog core to the
 * tick selector and the selected tick back.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface wwd_tick_if;
	logic [2:0] sel;	// Clock select code
	logic tick;	// One-cycle tick of the chosen source

	modport src(input sel, output tick);
	modport sink(output sel, input tick);
endinterface

`default_nettype wire

// [hw/wwd_tick_sel.sv]
/*
 * Picks one of the four oscillator tick strobes by clock select code and
 * registers it; reserved codes give no tick.
 * Assumes tick strobes are synchronous one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none

module wwd_tick_sel
	import wwd_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] osc_tick_i,
	wwd_tick_if.src tick_if
);

	// Whole state of the selector
	typedef struct packed {
		logic tick;
	} wwd_tick_state_t;

	wwd_tick_state_t s_q;	// Registered state
	wwd_tick_state_t s_d;	// Next state

	// Select the strobe; reserved codes stay silent
	always_comb begin
		s_d = s_q;
		if (tick_if.sel < CS_FIRST_RSVD) begin
			s_d.tick = osc_tick_i[tick_if.sel[1:0]];
		end else begin
			s_d.tick = 1'b0;
		end
	end

	// Register the state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick_if.tick = s_q.tick;

endmodule

`default_nettype wire

// [tb/wwd_core_asserts.sv]
/* Checker on the ports of wwd_core.
   Assumes it is bound from the bench top and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module wwd_core_asserts
	import wwd_pkg::*;
#(
	parameter int CNT_W = 23	// Same as the core
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [DATA_W-1:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [1:0] watchdog_mode_config_i,
	input wire logic sleep_i,
	input wire logic osc_fail_i,
	input wire logic wdt_reset_o,
	input wire logic wake_o,
	input wire logic expiry_flag_n_o,
	input wire logic sleep_entered_flag_n_o,
	input wire logic watchdog_reset_flag_n_o,
	input wire logic window_violation_flag_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_ONE_WAIT: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus answer late");
	AST_UPPER_ZERO: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	AST_WAKE_NO_RST: assert property (wake_o |-> !wdt_reset_o && $past(sleep_i))
		else $error("wake with reset or while awake");
	AST_WAKE_FLAGS: assert property (wake_o |-> ##[0:1] (!expiry_flag_n_o && !sleep_entered_flag_n_o))
		else $error("wake flags not set");
	AST_RST_FLAG: assert property (wdt_reset_o |-> ##[0:1] !watchdog_reset_flag_n_o)
		else $error("reset flag not set");
	AST_AWAKE_RST: assert property ($fell(expiry_flag_n_o) && !sleep_i |-> wdt_reset_o || $past(wdt_reset_o))
		else $error("awake expiry without reset");
	AST_SLEEP_CLR: assert property ($rose(sleep_i) |-> ##2 (!wake_o && !wdt_reset_o) [*8])
		else $error("count kept over sleep entry");
	AST_FAIL_HOLD: assert property (osc_fail_i [*3] |-> !wdt_reset_o && !wake_o)
		else $error("expiry during oscillator fail");
	AST_OFF: assert property (watchdog_mode_config_i == MODE_OFF [*3] |-> !wdt_reset_o && !wake_o)
		else $error("expiry while off");
	AST_VIOL: assert property ($fell(window_violation_flag_n_o) |-> wdt_reset_o || $past(wdt_reset_o))
		else $error("violation without reset");
endmodule
`default_nettype wire

// [tb/wwd_cpu_model.sv]
/* Processor-side model: oscillator tick strobes and clear instructions.
   Assumes the bench commands it just after rising edges. */
`timescale 1ns/1ps
`default_nettype none
module wwd_cpu_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_en_i,	// Run all four oscillators
	input wire logic clr_req_i,	// Issue one clear instruction
	output logic [3:0] osc_tick_o,	// Tick strobes
	output logic clr_o	// One-cycle clear pulse
);
	// Oscillators stand still while disabled; clear follows the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			osc_tick_o <= 4'h0;
			clr_o <= 1'b0;
		end else begin
			osc_tick_o <= {4{tick_en_i}};
			clr_o <= clr_req_i;
		end
	end
endmodule
`default_nettype wire

// [tb/wwd_core_tb.sv]
/* Bench for wwd_core: Avalon-MM tasks and sequences of calls.
   Assumes the checker and the processor model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module wwd_core_tb;
	import wwd_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [ADDR_W-1:0] avs_address_i = '0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [DATA_W-1:0] avs_writedata_i = '0;
	logic [BE_W-1:0] avs_byteenable_i = 4'hf;
	logic [DATA_W-1:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [1:0] watchdog_mode_config_i = MODE_ON;
	logic [3:0] osc_tick_i;
	logic sleep_i = 1'b0;
	logic watchdog_clear_instr_i;
	logic osc_fail_i = 1'b0;
	logic flags_restore_i = 1'b0;
	logic wdt_reset_o, wake_o, expiry_flag_n_o, sleep_entered_flag_n_o;
	logic watchdog_reset_flag_n_o, window_violation_flag_n_o;
	logic tick_en = 1'b0;	// Oscillators running
	logic clr_req = 1'b0;	// Clear instruction request
	logic [7:0] d;	// Last read byte
	logic [7:0] cod [3] = '{8'h00, 8'h02, 8'h26};	// Control words for period tests
	int per [3] = '{32, 64, 32};	// Ticks to expiry for each word
	int n_errors = 0, comparisons = 0, cyc = 0, n_rst = 0, n0, n;

	wwd_core dut (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .watchdog_mode_config_i,
		.period_config_i(5'h1f), .clock_config_i(3'h7), .window_config_i(3'h7), .osc_tick_i, .sleep_i,
		.watchdog_clear_instr_i, .osc_fail_i, .ost_running_i(1'b0), .crystal_clock_i(1'b0), .flags_restore_i,
		.wdt_reset_o, .wake_o, .expiry_flag_n_o, .sleep_entered_flag_n_o, .watchdog_reset_flag_n_o,
		.window_violation_flag_n_o);
	wwd_cpu_model cpu (.clk_i, .rst_i, .tick_en_i(tick_en), .clr_req_i(clr_req), .osc_tick_o(osc_tick_i),
		.clr_o(watchdog_clear_instr_i));

	// Clock, 8 ns period
	initial forever #4 clk_i = ~clk_i;
	// Cycle count, reset pulses seen, hang guard
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (wdt_reset_o === 1'b1) n_rst <= n_rst + 1;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up;
		end
	end

	task wrap_up;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, s, e);
		end
	endtask
	// One bus cycle, held until waitrequest is sampled low
	task bus(input logic w, input logic [7:0] idx, input logic [7:0] v, input logic [3:0] be);
		@(posedge clk_i);
		avs_address_i <= {idx, 2'b00};
		avs_writedata_i <= {24'h00_0000, v};
		avs_byteenable_i <= be;
		avs_read_i <= !w;
		avs_write_i <= w;
		@(posedge clk_i);
		while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
		d = avs_readdata_o[7:0];
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	task rchk(input logic [7:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00, 4'hf);
		chk(d, e);
	endtask
	// Cycles until a reset or wake pulse
	task measure;
		n = 0;
		while (wdt_reset_o !== 1'b1 && wake_o !== 1'b1) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	task clear;
		@(posedge clk_i);
		clr_req <= 1'b1;
		@(posedge clk_i);
		clr_req <= 1'b0;
	endtask
	task restore;
		@(posedge clk_i);
		flags_restore_i <= 1'b1;
		@(posedge clk_i);
		flags_restore_i <= 1'b0;
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(IDX_TIMER, 8'h00);
		rchk(IDX_PSC_LO, 8'h00);
		rchk(IDX_PSC_HI, 8'h00);
		rchk(IDX_CTRL_A, 8'h16);
		rchk(IDX_TIMER, 8'h04);
		rchk(IDX_CTRL_B, 8'h07);
		rchk(8'h00, 8'h00);
		bus(1'b1, IDX_CTRL_A, 8'h00, 4'he);
		rchk(IDX_CTRL_A, 8'h16);
		$display("test reset values done");
		tick_en <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, IDX_CTRL_A, cod[i], 4'hf);
			measure;
			chk(n >= per[i] && n <= per[i] + 6, 1'b1);
		end
		chk({expiry_flag_n_o, watchdog_reset_flag_n_o}, 2'b00);
		$display("test periods done");
		restore;
		bus(1'b1, IDX_CTRL_A, 8'h00, 4'hf);
		repeat (20) @(posedge clk_i);
		sleep_i <= 1'b1;
		measure;
		chk(n >= 32 && n <= 38, 1'b1);
		chk({wake_o, wdt_reset_o}, 2'b10);
		@(posedge clk_i);
		chk({expiry_flag_n_o, sleep_entered_flag_n_o, watchdog_reset_flag_n_o}, 3'b001);
		sleep_i <= 1'b0;
		$display("test sleep done");
		n0 = n_rst;
		repeat (6) begin
			repeat (20) @(posedge clk_i);
			clear;
		end
		osc_fail_i <= 1'b1;
		repeat (80) @(posedge clk_i);
		osc_fail_i <= 1'b0;
		watchdog_mode_config_i <= MODE_OFF;
		repeat (80) @(posedge clk_i);
		watchdog_mode_config_i <= MODE_ON;
		chk(n_rst - n0, 0);
		$display("test clearing done");
		bus(1'b1, IDX_CTRL_A, 8'h00, 4'hf);
		bus(1'b1, IDX_CTRL_B, 8'h06, 4'hf);
		rchk(IDX_CTRL_B, 8'h06);
		restore;
		n0 = n_rst;
		clear;
		repeat (4) @(posedge clk_i);
		chk({n_rst - n0 == 1, window_violation_flag_n_o, watchdog_reset_flag_n_o}, 3'b100);
		repeat (4) @(posedge clk_i);
		rchk(IDX_CTRL_A, 8'h00);
		n0 = n_rst;
		clear;
		repeat (4) @(posedge clk_i);
		chk(n_rst - n0, 0);
		$display("test window done");
		watchdog_mode_config_i <= MODE_SOFT;
		bus(1'b1, IDX_CTRL_B, 8'h07, 4'hf);
		n0 = n_rst;
		repeat (80) @(posedge clk_i);
		chk(n_rst - n0, 0);
		bus(1'b1, IDX_CTRL_A, 8'h01, 4'hf);
		measure;
		chk(n >= 32 && n <= 38, 1'b1);
		watchdog_mode_config_i <= MODE_NO_SLEEP;
		restore;
		sleep_i <= 1'b1;
		repeat (80) @(posedge clk_i);
		chk(expiry_flag_n_o, 1'b1);
		sleep_i <= 1'b0;
		$display("test modes done");
		wrap_up;
	end
endmodule

bind wwd_core wwd_core_asserts #(.CNT_W(CNT_W)) u_chk (.clk_i, .rst_i, .avs_read_i, .avs_write_i,
	.avs_readdata_o, .avs_waitrequest_o, .watchdog_mode_config_i, .sleep_i, .osc_fail_i, .wdt_reset_o,
	.wake_o, .expiry_flag_n_o, .sleep_entered_flag_n_o, .watchdog_reset_flag_n_o, .window_violation_flag_n_o);
`default_nettype wire
